/* hw/isec_pkg.sv */
package isec_pkg;

   // Timing at the 20 MHz system clock.
   localparam int unsigned CLK_HZ           = 20000000;
   localparam int unsigned BURST_PERIOD_NS  = 25000;
   localparam int unsigned ONE_SHOT_HIGH_NS = 2500;
   localparam int unsigned NS_PER_S         = 1000000000;
   localparam int unsigned BURST_CYCLES     = (BURST_PERIOD_NS / 50);
   localparam int unsigned ONE_SHOT_CYCLES  = (ONE_SHOT_HIGH_NS / 50);
   localparam int unsigned RAIL_READY_BURSTS = 4;

   // Power level codes; code 0 is the fallback for an out-of-range resistor.
   localparam logic [2:0] LEVEL_DEFAULT = 3'h0;
   localparam logic [2:0] LEVEL_MAX     = 3'h6;
   localparam logic [2:0] LEVEL_RESET   = 3'h0;

   // Burst on-time per level in cycles: n*2/15 of the 500-cycle period.
   localparam logic [8:0] ON_STEP_NUM  = 9'h002;
   localparam logic [8:0] ON_STEP_DEN  = 9'h00f;

   // Carrier spread: dither step count.
   localparam logic [3:0] SPREAD_RESET = 4'h1;

   typedef enum logic [1:0] {
      ISEC_STARTUP  = 2'b00,
      ISEC_TWO_WIRE = 2'b01,
      ISEC_THREE    = 2'b10
   } isec_mode_type;

endpackage : isec_pkg

/* hw/isec_ctrl.sv */
`timescale 1ns/1ns
// Function
// - Two-wire: power transfer starts when enable goes high.
// - Two-wire: gate rises only after secondary rails are ready.
// - Two-wire: enable low drops gate and stops power transfer.
// - Three-wire: power transfer runs regardless of enable level.
// - Three-wire: with rails ready, enable high raises gate, low lowers it.
// - Standard enable: gate tracks enable level.
// - One-shot: enable rising edge gives one self-terminating gate pulse.
// - One-shot: retrigger needs enable low then high again.
// - One-shot only on one-shot variant in three-wire mode.
// - Three-wire: transfer starts after power-up and runs while supply present.
// - Three-wire: bursts at fixed 25 us period, on-time varies with level.
// - Seven levels, duty 13.3 to 93.3 percent in 2/15 steps.
// - Power level sampled once at power-up and held.
// - Out-of-range resistor selects the lowest duty level.
// - Enable state is modulated onto a carrier driven differentially.
// - Carrier is spread in frequency, not a fixed tone.
// - Secondary decodes carrier and sets gate from decoded state.
// - Loss of secondary power holds the gate low.
// - One-shot pulse lasts 2.5 us.
// - Two- or three-wire chosen at power-up and kept.
module isec_ctrl (
   input  wire logic             CLK_SYS,          // 20 MHz system clock
   input  wire logic             RST_N,            // Power-up reset, active low
   input  wire logic             EN_PIN,           // Enable pin, asynchronous
   input  wire logic             PRIMARY_SUPPLY_RAIL, // Dedicated supply present
   input  wire logic             ONE_SHOT_VARIANT, // Strap: one-shot variant
   input  wire logic [2:0]       POWER_LEVEL_SELECT_PIN, // Resistor decode 0..6
   input  wire logic             LEVEL_RANGE_OK,   // Resistor within valid range
   input  wire logic             SECONDARY_RAIL_OK, // Secondary rails above lockout
   output logic                  CARRIER_P,        // Transformer drive, positive
   output logic                  CARRIER_N,        // Transformer drive, negative
   output logic                  TX_ACTIVE,        // Burst on-time active
   output logic                  GATE_DRIVE,       // Gate drive output
   output logic [1:0]            MODE,             // Operating mode
   output logic [2:0]            LEVEL             // Latched power level
);
   import isec_pkg::*;

   typedef struct packed {
      logic [2:0]    en_sync;
      logic          en_state;
      logic          supply_q;
      isec_mode_type mode;
      logic          one_shot;
      logic [2:0]    level;
      logic [8:0]    period_cnt;
      logic [3:0]    spread;
      logic [3:0]    spread_cnt;
      logic          carrier;
      logic          tx;
      logic          tx_data;
      logic          rx_state;
      logic [2:0]    ready_bursts;
      logic          gate;
      logic          armed;
      logic [5:0]    pulse_cnt;
      logic [9:0]    burst_gap;
   } isec_state_type;

   isec_state_type st;
   isec_state_type next_st;

   // The product reaches 7000 before the divide, so it is formed at 14 bits.
   function automatic logic [8:0] on_cycles(input logic [2:0] lvl);
      logic [13:0] n;
      logic [13:0] prod;
      n = {11'h000, lvl} + 14'h0001;
      prod = (n * 14'(ON_STEP_NUM) * 14'(BURST_CYCLES)) / 14'(ON_STEP_DEN);
      on_cycles = prod[8:0];
   endfunction : on_cycles

   logic sup_now;
   logic tx_on;
   logic rails_ready;

   always_comb begin
      next_st = st;
      sup_now = 1'b0;
      tx_on = 1'b0;
      rails_ready = 1'b0;

      // Three-stage pin synchroniser; only stages two and three are compared.
      next_st.en_sync = {st.en_sync[1:0], EN_PIN};
      if (st.en_sync[1] == st.en_sync[2]) begin
         next_st.en_state = st.en_sync[2];
      end
      next_st.supply_q = PRIMARY_SUPPLY_RAIL;

      // Mode, variant and level are caught once on the first cycle after reset.
      if (st.mode == ISEC_STARTUP) begin
         next_st.mode = PRIMARY_SUPPLY_RAIL ? ISEC_THREE : ISEC_TWO_WIRE;
         next_st.one_shot = ONE_SHOT_VARIANT & PRIMARY_SUPPLY_RAIL;
         if (LEVEL_RANGE_OK && POWER_LEVEL_SELECT_PIN <= LEVEL_MAX) begin
            next_st.level = POWER_LEVEL_SELECT_PIN;
         end else begin
            next_st.level = LEVEL_DEFAULT;
         end
      end

      unique case (st.mode)
         ISEC_THREE:    sup_now = st.supply_q;
         ISEC_TWO_WIRE: sup_now = st.en_state;
         default:       sup_now = 1'b0;
      endcase

      // Fixed period, level-dependent on-time.
      if (!sup_now || st.period_cnt == 9'(BURST_CYCLES - 1)) begin
         next_st.period_cnt = 9'h000;
      end else begin
         next_st.period_cnt = st.period_cnt + 9'h001;
      end
      tx_on = sup_now && (st.period_cnt < on_cycles(st.level));
      next_st.tx = tx_on;

      // Spacing of burst starts, kept only for the period check below.
      // It saturates, so a very long gap cannot wrap round to a legal count.
      if (!sup_now) begin
         next_st.burst_gap = 10'h000;
      end else if (tx_on && !st.tx) begin
         next_st.burst_gap = 10'h001;
      end else if (st.burst_gap != 10'h000 && st.burst_gap != 10'h3ff) begin
         next_st.burst_gap = st.burst_gap + 10'h001;
      end

      // Spread carrier: half-period length hops between 1 and 4 cycles.
      if (tx_on) begin
         if (st.spread_cnt >= st.spread) begin
            next_st.spread_cnt = 4'h0;
            next_st.carrier = ~st.carrier;
            next_st.spread = (st.spread == 4'h3) ? 4'h0 : st.spread + 4'h1;
         end else begin
            next_st.spread_cnt = st.spread_cnt + 4'h1;
         end
         next_st.tx_data = st.en_state;
      end else begin
         next_st.carrier = 1'b0;
         next_st.spread_cnt = 4'h0;
      end

      // Secondary side: decode the state carried by each burst.
      if (st.tx) begin
         next_st.rx_state = st.tx_data;
      end
      if (!SECONDARY_RAIL_OK || !sup_now) begin
         next_st.ready_bursts = 3'h0;
      end else if (st.tx && !tx_on && st.ready_bursts != 3'(RAIL_READY_BURSTS)) begin
         next_st.ready_bursts = st.ready_bursts + 3'h1;
      end
      rails_ready = SECONDARY_RAIL_OK && (st.ready_bursts == 3'(RAIL_READY_BURSTS));

      if (!rails_ready || (st.mode == ISEC_TWO_WIRE && !st.en_state)) begin
         next_st.gate = 1'b0;
         next_st.pulse_cnt = 6'h00;
         next_st.armed = !st.rx_state;
      end else if (!st.one_shot) begin
         next_st.gate = st.rx_state;
      end else begin
         if (!st.rx_state) begin
            next_st.armed = 1'b1;
            next_st.gate = 1'b0;
            next_st.pulse_cnt = 6'h00;
         end else if (st.armed) begin
            next_st.armed = 1'b0;
            next_st.gate = 1'b1;
            next_st.pulse_cnt = 6'h01;
         end else if (st.gate) begin
            if (st.pulse_cnt == 6'(ONE_SHOT_CYCLES)) begin
               next_st.gate = 1'b0;
            end else begin
               next_st.pulse_cnt = st.pulse_cnt + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st <= '{en_sync: 3'h0, en_state: 1'b0, supply_q: 1'b0, mode: ISEC_STARTUP,
                 one_shot: 1'b0, level: LEVEL_RESET, period_cnt: 9'h000,
                 spread: SPREAD_RESET, spread_cnt: 4'h0, carrier: 1'b0, tx: 1'b0,
                 tx_data: 1'b0, rx_state: 1'b0, ready_bursts: 3'h0, gate: 1'b0,
                 armed: 1'b0, pulse_cnt: 6'h00, burst_gap: 10'h000};
      end else begin
         st <= next_st;
      end
   end

   assign CARRIER_P  = st.carrier;
   assign CARRIER_N  = st.tx & ~st.carrier;
   assign TX_ACTIVE  = st.tx;
   assign GATE_DRIVE = st.gate;
   assign MODE       = st.mode;
   assign LEVEL      = st.level;

   property p_gate_off_no_rail;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !SECONDARY_RAIL_OK |=> !GATE_DRIVE;
   endproperty
   a_gate_off_no_rail: assert property (p_gate_off_no_rail) else $error("gate high without rail");

   property p_two_wire_off;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode == ISEC_TWO_WIRE && !st.en_state) |=> (!GATE_DRIVE && !TX_ACTIVE);
   endproperty
   a_two_wire_off: assert property (p_two_wire_off) else $error("two-wire off not honoured");

   property p_three_wire_tx;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode == ISEC_THREE && st.supply_q && st.period_cnt == 9'h000) |=> TX_ACTIVE;
   endproperty
   a_three_wire_tx: assert property (p_three_wire_tx) else $error("no burst start");

   // A burst start that follows an earlier one must be exactly one period later.
   property p_period;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode == ISEC_THREE && tx_on && !st.tx && st.burst_gap != 10'h000)
            |-> (st.burst_gap == 10'(BURST_CYCLES));
   endproperty
   a_period: assert property (p_period)
      else $error("burst period wrong");

   property p_gate_needs_ready;
      @(posedge CLK_SYS) disable iff (!RST_N)
         $rose(GATE_DRIVE) |-> $past(rails_ready);
   endproperty
   a_gate_needs_ready: assert property (p_gate_needs_ready) else $error("gate before ready");

   property p_one_shot_len;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.one_shot && $rose(GATE_DRIVE)) |-> ##[1:50] !GATE_DRIVE;
   endproperty
   a_one_shot_len: assert property (p_one_shot_len) else $error("one-shot too long");

   property p_no_retrigger;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.one_shot && $fell(GATE_DRIVE) && st.rx_state) |=> !GATE_DRIVE;
   endproperty
   a_no_retrigger: assert property (p_no_retrigger) else $error("one-shot retriggered");

   property p_level_held;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode != ISEC_STARTUP) |=> $stable(LEVEL) && $stable(MODE);
   endproperty
   a_level_held: assert property (p_level_held) else $error("level or mode changed");

   property p_follow;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (!st.one_shot && rails_ready && st.mode == ISEC_THREE) |=> GATE_DRIVE == $past(st.rx_state);
   endproperty
   a_follow: assert property (p_follow) else $error("gate does not follow");

   // The two carrier legs must be complementary whenever a burst is on.
   property p_carrier_diff;
      @(posedge CLK_SYS) disable iff (!RST_N)
         TX_ACTIVE |-> (CARRIER_P != CARRIER_N);
   endproperty
   a_carrier_diff: assert property (p_carrier_diff)
      else $error("carrier not differential");

   // Between bursts both legs rest low, so the transformer sees no drive.
   property p_carrier_idle;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !TX_ACTIVE |-> (!CARRIER_P && !CARRIER_N);
   endproperty
   a_carrier_idle: assert property (p_carrier_idle)
      else $error("carrier driven outside burst");

   // The dither step stays inside its four hop lengths.
   property p_spread_hop;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.spread <= 4'h3) && (st.spread_cnt <= 4'h3);
   endproperty
   a_spread_hop: assert property (p_spread_hop)
      else $error("spread step out of range");

   property p_level_range;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode != ISEC_STARTUP) |-> (LEVEL <= LEVEL_MAX);
   endproperty
   a_level_range: assert property (p_level_range)
      else $error("level code out of range");

   // The mode taken on the first edge must match the supply seen there.
   property p_mode_latch;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode == ISEC_STARTUP) |=> ((MODE == 2'(ISEC_THREE)) == $past(PRIMARY_SUPPLY_RAIL));
   endproperty
   a_mode_latch: assert property (p_mode_latch)
      else $error("mode latched wrongly");

   // One-shot behaviour is never allowed in two-wire operation.
   property p_one_shot_three;
      @(posedge CLK_SYS) disable iff (!RST_N)
         st.one_shot |-> (st.mode != ISEC_TWO_WIRE);
   endproperty
   a_one_shot_three: assert property (p_one_shot_three)
      else $error("one-shot outside three-wire");

   property p_rx_decode;
      @(posedge CLK_SYS) disable iff (!RST_N)
         st.tx |=> (st.rx_state == $past(st.tx_data));
   endproperty
   a_rx_decode: assert property (p_rx_decode)
      else $error("received state not decoded");

   property p_embed_state;
      @(posedge CLK_SYS) disable iff (!RST_N)
         tx_on |=> (st.tx_data == $past(st.en_state));
   endproperty
   a_embed_state: assert property (p_embed_state)
      else $error("burst lost the enable state");

   // The pulse counter never runs past the one-shot length.
   property p_pulse_bound;
      @(posedge CLK_SYS) disable iff (!RST_N)
         st.one_shot |-> (st.pulse_cnt <= 6'(ONE_SHOT_CYCLES));
   endproperty
   a_pulse_bound: assert property (p_pulse_bound)
      else $error("one-shot counter overrun");

   // A decoded low always pulls the gate down in three-wire operation.
   property p_low_follow;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (st.mode == ISEC_THREE && rails_ready && !st.rx_state) |=> !GATE_DRIVE;
   endproperty
   a_low_follow: assert property (p_low_follow)
      else $error("gate high after decoded low");

   c_one_shot: cover property (@(posedge CLK_SYS) disable iff (!RST_N) st.one_shot && $fell(GATE_DRIVE));
   c_three_gate: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
      st.mode == ISEC_THREE && !st.one_shot && $rose(GATE_DRIVE));
   c_gate_on:  cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(GATE_DRIVE));
   c_two_wire: cover property (@(posedge CLK_SYS) disable iff (!RST_N) st.mode == ISEC_TWO_WIRE && TX_ACTIVE);

endmodule : isec_ctrl

/* testbench/isec_en_model.sv */
`timescale 1ns/1ns
module isec_en_model #(
   parameter int MIN_HOLD = 100
) (
   input  wire logic clk,  // System clock
   input  wire logic req,  // Requested enable level
   output logic      en    // Enable pin drive
);
   int held = 0;
   initial en = 1'b0;
   // Each level stands at least 5 us, so every new rise follows a low that was seen.
   always @(negedge clk) begin
      if (req !== en && held >= MIN_HOLD) begin
         en <= req;
         held <= 0;
      end else begin
         held <= held + 1;
      end
   end
endmodule : isec_en_model

/* testbench/tb_isec_ctrl.sv */
`timescale 1ns/1ns
module tb_isec_ctrl;
   import isec_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       en_req = 1'b0;
   logic       en_pin;
   logic       supply = 1'b1;
   logic       variant = 1'b0;
   logic [2:0] pin_level = 3'h0;
   logic       range_ok = 1'b1;
   logic       rail_ok = 1'b1;
   logic       car_p, car_n, tx, gate;
   logic [1:0] mode;
   logic [2:0] level;
   int         err_count = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         on, per, c;

   isec_en_model isec_en_model_i (.clk(clk_sys), .req(en_req), .en(en_pin));
   isec_ctrl isec_ctrl_i (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .EN_PIN(en_pin), .PRIMARY_SUPPLY_RAIL(supply),
      .ONE_SHOT_VARIANT(variant), .POWER_LEVEL_SELECT_PIN(pin_level),
      .LEVEL_RANGE_OK(range_ok), .SECONDARY_RAIL_OK(rail_ok), .CARRIER_P(car_p),
      .CARRIER_N(car_n), .TX_ACTIVE(tx), .GATE_DRIVE(gate), .MODE(mode), .LEVEL(level));

   initial forever #25 clk_sys = ~clk_sys;

   // The full run needs about 22000 cycles; the ceiling leaves a wide margin.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic power_up(input logic sup, input logic osv, input logic [2:0] pl,
                           input logic ok);
      @(negedge clk_sys);
      rst_n = 1'b0;
      supply = sup;
      variant = osv;
      pin_level = pl;
      range_ok = ok;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask : power_up

   // Counts cycles with the gate (sel high) or the burst flag high over a window.
   task automatic count_high(input bit sel, input int win, output int cnt);
      cnt = 0;
      repeat (win) begin
         cnt += sel ? int'(gate === 1'b1) : int'(tx === 1'b1);
         @(negedge clk_sys);
      end
   endtask : count_high

   task automatic wait_gate(input logic v, input int lim);
      int n;
      n = 0;
      while (gate !== v && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      check(16'(gate), 16'(v));
   endtask : wait_gate

   // Measures one burst on-time and the rise-to-rise period of the burst flag.
   task automatic measure_burst(output int hi, output int pd);
      int bad;
      bad = 0;
      hi = 0;
      while (tx !== 1'b1 && hi < 1200) begin
         @(negedge clk_sys);
         hi++;
      end
      hi = 0;
      while (tx === 1'b1 && hi < 1000) begin
         bad += int'(car_p === car_n && hi > 2);
         @(negedge clk_sys);
         hi++;
      end
      pd = hi;
      while (tx !== 1'b1 && pd < 1000) begin
         @(negedge clk_sys);
         pd++;
      end
      check(16'(bad), 16'h0000);
   endtask : measure_burst

   task automatic t_levels();
      for (int l = 0; l < 7; l++) begin
         power_up(1'b1, 1'b0, 3'(l), 1'b1);
         check(16'(mode), 16'(ISEC_THREE));
         check(16'(level), 16'(l));
         measure_burst(on, per);
         check(16'(on), 16'(((l + 1) * 1000) / 15));
         check(16'(per), 16'(BURST_CYCLES));
      end
   endtask : t_levels

   task automatic t_range();
      power_up(1'b1, 1'b0, 3'h6, 1'b0);
      check(16'(level), 16'(LEVEL_DEFAULT));
      measure_burst(on, per);
      check(16'(on), 16'h0042);
      pin_level = 3'h3;
      range_ok = 1'b1;
      measure_burst(on, per);
      check(16'(level), 16'(LEVEL_DEFAULT));
      check(16'(on), 16'h0042);
   endtask : t_range

   task automatic t_standard();
      power_up(1'b1, 1'b0, 3'h0, 1'b1);
      repeat (2600) @(negedge clk_sys);
      check(16'(gate), 16'h0000);
      en_req = 1'b1;
      wait_gate(1'b1, 700);
      count_high(1'b1, 1500, c);
      check(16'(c), 16'd1500);
      rail_ok = 1'b0;
      wait_gate(1'b0, 700);
      rail_ok = 1'b1;
      wait_gate(1'b1, 3200);
      en_req = 1'b0;
      wait_gate(1'b0, 700);
   endtask : t_standard

   task automatic t_one_shot();
      power_up(1'b1, 1'b1, 3'h0, 1'b1);
      repeat (2600) @(negedge clk_sys);
      en_req = 1'b1;
      wait_gate(1'b1, 700);
      count_high(1'b1, 1500, c);
      check(16'(c), 16'(ONE_SHOT_CYCLES));
      en_req = 1'b0;
      repeat (1100) @(negedge clk_sys);
      en_req = 1'b1;
      wait_gate(1'b1, 700);
   endtask : t_one_shot

   task automatic t_two_wire();
      en_req = 1'b0;
      // The partner keeps each level a minimum time, so let the low settle first.
      repeat (200) @(negedge clk_sys);
      power_up(1'b0, 1'b0, 3'h0, 1'b1);
      check(16'(mode), 16'(ISEC_TWO_WIRE));
      count_high(1'b0, 1100, c);
      check(16'(c), 16'h0000);
      supply = 1'b1;
      en_req = 1'b1;
      measure_burst(on, per);
      check(16'(on), 16'h0042);
      check(16'(gate), 16'h0000);
      wait_gate(1'b1, 3500);
      check(16'(mode), 16'(ISEC_TWO_WIRE));
      en_req = 1'b0;
      wait_gate(1'b0, 700);
      repeat (600) @(negedge clk_sys);
      count_high(1'b0, 1100, c);
      check(16'(c), 16'h0000);
   endtask : t_two_wire

   initial begin
      t_levels();
      t_range();
      t_standard();
      t_one_shot();
      t_two_wire();
      complete_run();
   end
endmodule : tb_isec_ctrl
